// ### hw/serial_port_pkg.sv
// Shared constants and types for the asynchronous serial port
package serial_port_pkg;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [4:0] OFS_SERIAL_CONTROL_STATUS = 5'h00;
    localparam logic [4:0] OFS_SERIAL_FORMAT_CONFIG = 5'h04;
    localparam logic [4:0] OFS_SERIAL_DATA_PORT = 5'h08;
    localparam logic [4:0] OFS_BAUD_GEN_CONTROL = 5'h0C;
    localparam logic [4:0] OFS_BAUD_RELOAD_HIGH = 5'h10;
    localparam logic [4:0] OFS_BAUD_RELOAD_LOW = 5'h14;

    // Values after reset
    localparam logic [7:0] CONTROL_STATUS_RESET = 8'h20;
    localparam logic [7:0] FORMAT_CONFIG_RESET = 8'h0C;
    localparam logic [7:0] BAUD_GEN_CONTROL_RESET = 8'h00;
    localparam logic [15:0] BAUD_RELOAD_RESET = 16'h0000;

    // Prescaler selection codes and the matching last count of the prescaler
    localparam logic [1:0] PRESCALE_SEL_12 = 2'h0;
    localparam logic [1:0] PRESCALE_SEL_4 = 2'h1;
    localparam logic [1:0] PRESCALE_SEL_48 = 2'h2;
    localparam logic [1:0] PRESCALE_SEL_1 = 2'h3;
    localparam logic [5:0] PRESCALE_LAST_12 = 6'h0B;
    localparam logic [5:0] PRESCALE_LAST_4 = 6'h03;
    localparam logic [5:0] PRESCALE_LAST_48 = 6'h2F;
    localparam logic [5:0] PRESCALE_LAST_1 = 6'h00;
    localparam logic [15:0] TIMER_ALL_ONES = 16'hFFFF;

    // Parity type codes
    localparam logic [1:0] PARITY_ODD = 2'h0;
    localparam logic [1:0] PARITY_EVEN = 2'h1;
    localparam logic [1:0] PARITY_MARK = 2'h2;
    localparam logic [1:0] PARITY_SPACE = 2'h3;

    // Last half-bit index of a slot; one timer overflow is half a bit time
    localparam logic [1:0] HALVES_LAST_BIT = 2'h1;
    localparam logic [1:0] HALVES_LAST_STOP_1P5 = 2'h2;
    localparam logic [1:0] HALVES_LAST_STOP_2 = 2'h3;

    localparam int RX_FIFO_DEPTH = 3;
    localparam logic [1:0] RX_FIFO_FULL = 2'h3;
    localparam logic [1:0] RX_FIFO_ONE = 2'h1;

    typedef struct packed {
        logic overrun;
        logic parity_err;
        logic hold_empty;
        logic rx_enable;
        logic tx_extra_bit;
        logic rx_extra_bit;
        logic transmit_done_flag;
        logic receive_ready_flag;
    } control_status_t;

    typedef struct packed {
        logic multiproc_address_enable;
        logic parity_enable;
        logic [1:0] parity_type;
        logic [1:0] length_code;
        logic extra_bit_enable;
        logic long_stop;
    } format_config_t;

    typedef struct packed {
        logic irq_enable;
        logic gen_enable;
        logic [3:0] reserved;
        logic [1:0] baud_prescale_select;
    } baud_gen_control_t;

    typedef enum logic [2:0] {PH_IDLE, PH_START, PH_DATA, PH_EXTRA, PH_STOP} phase_t;

    typedef struct packed {
        logic extra;
        logic [7:0] data;
    } rx_entry_t;

    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
        control_status_t ctrl;
        format_config_t fmt;
        baud_gen_control_t bctl;
        logic [15:0] reload;
        logic irq;
        logic [7:0] hold;
        logic [5:0] presc;
        logic [15:0] timer;
        phase_t tx;
        logic [7:0] tx_shift;
        logic [2:0] tx_bit;
        logic [1:0] tx_half;
        logic tx_xbit;
        logic txd;
        logic [2:0] sync;
        logic rx_lvl;
        phase_t rx;
        logic [15:0] rx_timer;
        logic rx_phase;
        logic [7:0] rx_shift;
        logic [2:0] rx_bit;
        logic rx_xbit;
        rx_entry_t [RX_FIFO_DEPTH-1:0] fifo;
        logic [1:0] count;
    } state_t;

endpackage

// ### hw/serial_port.sv
// Asynchronous full-duplex serial port with baud timer, receive queue and Avalon-MM registers
// Behaviour
// - Transmit and receive run concurrently; receive queue holds three bytes before loss.
// - Data register writes fill the holding register, reads return oldest queued byte.
// - With interrupts enabled, transmit-done or receive-ready raises the interrupt request.
// - Transmit-done and receive-ready stay set until software clears them.
// - Software cannot clear receive-ready while further unread bytes remain queued.
// - Baud generator is a 16-bit timer behind a 1, 4, 12 or 48 prescaler.
// - Baud control holds generator enable and prescale; port runs only while enabled.
// - Reload value comes from separate high and low byte registers.
// - Timer counts up per prescaled tick and reloads when wrapping past all-ones.
// - Baud equals clock over prescale over (65536 minus reload), halved.
// - Frame is low start, data LSB first, optional parity/extra, high stops.
// - Data length programmable from five to eight bits in the format register.
// - Parity generated and checked, type even, odd, mark or space.
// - Short stop is one bit; long is 1.5 bits for 5 data, else 2.
// - Two-bit stop is offered only for six, seven or eight data bits.
// - With parity enabled the extra-bit feature is unavailable.
// - Multiprocessor mode uses the extra bit to mark address frames.
// - Transmit-done sets when the stop-bit time begins.
// - Byte completing into a full queue is dropped and sets overrun flag.
// - Byte with zero stop bit is not queued and raises no receive-ready.
// - In multiprocessor mode receive-ready rises only when the extra bit is one.
//
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
module serial_port
    import serial_port_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic rxd_i,
    output logic txd_o,
    output logic serial_irq_o
);

    state_t s;
    state_t next_s;

    logic bus_req;
    logic accept;
    logic [5:0] presc_last;
    logic gen_tick;
    logic tmr_ovf;
    logic rx_ovf;
    logic [2:0] len_last;
    logic has_extra;
    logic [1:0] stop_last;
    logic [1:0] tx_last;

    function automatic logic parity_of(input logic [7:0] d, input format_config_t f);
        logic [7:0] m;
        logic r;
        m = 8'hFF >> (2'h3 - f.length_code);
        unique case (f.parity_type)
            PARITY_ODD: r = ~^(d & m);
            PARITY_EVEN: r = ^(d & m);
            PARITY_MARK: r = 1'b1;
            PARITY_SPACE: r = 1'b0;
        endcase
        return r;
    endfunction

    // One wait state: the request is registered, then answered
    assign bus_req = avs_read_i | avs_write_i;
    assign accept = bus_req & s.ack;
    assign avs_waitrequest_o = bus_req & ~s.ack;
    assign avs_readdata_o = {24'h0000_00, s.rdata};
    assign txd_o = s.txd;
    assign serial_irq_o = s.irq;

    always_comb
    begin
        unique case (s.bctl.baud_prescale_select)
            PRESCALE_SEL_12: presc_last = PRESCALE_LAST_12;
            PRESCALE_SEL_4: presc_last = PRESCALE_LAST_4;
            PRESCALE_SEL_48: presc_last = PRESCALE_LAST_48;
            PRESCALE_SEL_1: presc_last = PRESCALE_LAST_1;
        endcase
    end

    assign gen_tick = s.bctl.gen_enable & (s.presc == presc_last);
    assign tmr_ovf = gen_tick & (s.timer == TIMER_ALL_ONES);
    assign rx_ovf = gen_tick & (s.rx_timer == TIMER_ALL_ONES);
    assign len_last = {1'b1, s.fmt.length_code};
    assign has_extra = s.fmt.parity_enable | s.fmt.extra_bit_enable;
    // 1.5 stop bits exist only for five data bits, so two stop bits never pair with them
    assign stop_last = !s.fmt.long_stop ? HALVES_LAST_BIT
        : (s.fmt.length_code == 2'h0) ? HALVES_LAST_STOP_1P5 : HALVES_LAST_STOP_2;
    assign tx_last = (s.tx == PH_STOP) ? stop_last : HALVES_LAST_BIT;

    always_comb
    begin
        control_status_t wctl;
        logic [7:0] rd;
        logic ti_set;
        logic ri_set;
        logic ovr_set;
        logic perr_set;
        logic do_push;
        rx_entry_t entry;
        wctl = control_status_t'(avs_writedata_i[7:0]);
        rd = 8'h00;
        ti_set = 1'b0;
        ri_set = 1'b0;
        ovr_set = 1'b0;
        perr_set = 1'b0;
        do_push = 1'b0;
        entry = '0;
        next_s = s;
        next_s.ack = 1'b0;

        // Baud timer; while disabled it waits at the reload value
        if (!s.bctl.gen_enable)
        begin
            next_s.presc = 6'h00;
            next_s.timer = s.reload;
        end
        else if (gen_tick)
        begin
            next_s.presc = 6'h00;
            next_s.timer = tmr_ovf ? s.reload : s.timer + 16'h0001;
        end
        else
        begin
            next_s.presc = s.presc + 6'h01;
        end
        if (gen_tick)
        begin
            next_s.rx_timer = rx_ovf ? s.reload : s.rx_timer + 16'h0001;
        end

        // Transmitter; a frame stalls if the generator is turned off mid-frame
        unique case (s.tx)
            PH_IDLE:
            begin
                if (s.bctl.gen_enable && !s.ctrl.hold_empty)
                begin
                    next_s.tx_shift = s.hold;
                    next_s.ctrl.hold_empty = 1'b1;
                    next_s.tx_xbit = s.fmt.parity_enable ? parity_of(s.hold, s.fmt) : s.ctrl.tx_extra_bit;
                    next_s.tx = PH_START;
                    next_s.txd = 1'b0;
                    next_s.tx_half = 2'h0;
                end
            end
            default:
            begin
                if (tmr_ovf && s.tx_half != tx_last)
                begin
                    next_s.tx_half = s.tx_half + 2'h1;
                end
                else if (tmr_ovf)
                begin
                    next_s.tx_half = 2'h0;
                    unique case (s.tx)
                        PH_START:
                        begin
                            next_s.tx = PH_DATA;
                            next_s.tx_bit = 3'h0;
                            next_s.txd = s.tx_shift[0];
                        end
                        PH_DATA:
                        begin
                            if (s.tx_bit != len_last)
                            begin
                                next_s.tx_shift = s.tx_shift >> 1;
                                next_s.tx_bit = s.tx_bit + 3'h1;
                                next_s.txd = s.tx_shift[1];
                            end
                            else if (has_extra)
                            begin
                                next_s.tx = PH_EXTRA;
                                next_s.txd = s.tx_xbit;
                            end
                            else
                            begin
                                next_s.tx = PH_STOP;
                                next_s.txd = 1'b1;
                                ti_set = 1'b1;
                            end
                        end
                        PH_EXTRA:
                        begin
                            next_s.tx = PH_STOP;
                            next_s.txd = 1'b1;
                            ti_set = 1'b1;
                        end
                        PH_STOP: next_s.tx = PH_IDLE;
                        PH_IDLE: next_s.tx = PH_IDLE;
                    endcase
                end
            end
        endcase

        // Receive line: three stages, the level moves only when stages two and three agree
        next_s.sync = {s.sync[1:0], rxd_i};
        if (s.sync[1] == s.sync[2])
        begin
            next_s.rx_lvl = s.sync[2];
        end

        // Receiver runs its own timer restarted at the start edge so sampling sits mid-bit
        if (!s.ctrl.rx_enable || !s.bctl.gen_enable)
        begin
            next_s.rx = PH_IDLE;
        end
        else
        begin
            unique case (s.rx)
                PH_IDLE:
                begin
                    if (!s.rx_lvl)
                    begin
                        next_s.rx = PH_START;
                        next_s.rx_timer = s.reload;
                        next_s.rx_phase = 1'b0;
                    end
                end
                PH_START:
                begin
                    if (rx_ovf)
                    begin
                        // Half a bit in: a high line here was a glitch, not a start bit
                        next_s.rx = s.rx_lvl ? PH_IDLE : PH_DATA;
                        next_s.rx_bit = 3'h0;
                        next_s.rx_shift = 8'h00;
                        next_s.rx_xbit = 1'b0;
                        next_s.rx_phase = 1'b0;
                    end
                end
                default:
                begin
                    if (rx_ovf)
                    begin
                        next_s.rx_phase = ~s.rx_phase;
                    end
                    if (rx_ovf && s.rx_phase)
                    begin
                        unique case (s.rx)
                            PH_DATA:
                            begin
                                next_s.rx_shift[s.rx_bit] = s.rx_lvl;
                                next_s.rx_bit = s.rx_bit + 3'h1;
                                if (s.rx_bit == len_last)
                                begin
                                    next_s.rx = has_extra ? PH_EXTRA : PH_STOP;
                                end
                            end
                            PH_EXTRA:
                            begin
                                next_s.rx_xbit = s.rx_lvl;
                                perr_set = s.fmt.parity_enable & (s.rx_lvl != parity_of(s.rx_shift, s.fmt));
                                next_s.rx = PH_STOP;
                            end
                            PH_STOP:
                            begin
                                next_s.rx = PH_IDLE;
                                entry.data = s.rx_shift;
                                entry.extra = (s.fmt.extra_bit_enable && !s.fmt.parity_enable) ? s.rx_xbit : s.rx_lvl;
                                do_push = s.rx_lvl;
                                ri_set = s.rx_lvl & (!s.fmt.multiproc_address_enable | s.rx_xbit);
                            end
                            PH_START: next_s.rx = PH_START;
                            PH_IDLE: next_s.rx = PH_IDLE;
                        endcase
                    end
                end
            endcase
        end

        // Register reads are captured while waitrequest is high
        unique case (avs_address_i)
            OFS_SERIAL_CONTROL_STATUS: rd = s.ctrl;
            OFS_SERIAL_FORMAT_CONFIG: rd = s.fmt;
            OFS_SERIAL_DATA_PORT: rd = s.fifo[0].data;
            OFS_BAUD_GEN_CONTROL: rd = s.bctl;
            OFS_BAUD_RELOAD_HIGH: rd = s.reload[15:8];
            OFS_BAUD_RELOAD_LOW: rd = s.reload[7:0];
            default: rd = 8'h00;
        endcase
        if (bus_req && !s.ack)
        begin
            next_s.ack = 1'b1;
            next_s.rdata = avs_read_i ? rd : 8'h00;
        end

        // Writes land after the transmitter so a fresh byte is never lost to the load
        if (accept && avs_write_i && avs_byteenable_i[0])
        begin
            unique case (avs_address_i)
                OFS_SERIAL_CONTROL_STATUS:
                begin
                    next_s.ctrl.overrun = wctl.overrun;
                    next_s.ctrl.parity_err = wctl.parity_err;
                    next_s.ctrl.rx_enable = wctl.rx_enable;
                    next_s.ctrl.tx_extra_bit = wctl.tx_extra_bit;
                    next_s.ctrl.transmit_done_flag = wctl.transmit_done_flag;
                    if (wctl.receive_ready_flag || s.count <= RX_FIFO_ONE)
                    begin
                        next_s.ctrl.receive_ready_flag = wctl.receive_ready_flag;
                    end
                end
                OFS_SERIAL_FORMAT_CONFIG:
                begin
                    next_s.fmt = format_config_t'(avs_writedata_i[7:0]);
                    if (avs_writedata_i[6])
                    begin
                        next_s.fmt.extra_bit_enable = 1'b0;
                    end
                end
                OFS_SERIAL_DATA_PORT:
                begin
                    next_s.hold = avs_writedata_i[7:0];
                    next_s.ctrl.hold_empty = 1'b0;
                end
                OFS_BAUD_GEN_CONTROL:
                begin
                    next_s.bctl = baud_gen_control_t'(avs_writedata_i[7:0]);
                    next_s.bctl.reserved = 4'h0;
                end
                OFS_BAUD_RELOAD_HIGH: next_s.reload[15:8] = avs_writedata_i[7:0];
                OFS_BAUD_RELOAD_LOW: next_s.reload[7:0] = avs_writedata_i[7:0];
                default: next_s.ack = 1'b0;
            endcase
        end

        // Reading the data port drops the oldest byte; a same-cycle arrival then sees the space
        if (accept && avs_read_i && avs_address_i == OFS_SERIAL_DATA_PORT && s.count != 2'h0)
        begin
            next_s.fifo[0] = s.fifo[1];
            next_s.fifo[1] = s.fifo[2];
            next_s.count = s.count - 2'h1;
        end
        if (do_push && next_s.count == RX_FIFO_FULL)
        begin
            ovr_set = 1'b1;
            ri_set = 1'b0;
        end
        else if (do_push)
        begin
            next_s.fifo[next_s.count] = entry;
            next_s.count = next_s.count + 2'h1;
        end

        // Hardware sets win over a software clear in the same cycle
        if (ti_set)
        begin
            next_s.ctrl.transmit_done_flag = 1'b1;
        end
        if (ri_set)
        begin
            next_s.ctrl.receive_ready_flag = 1'b1;
        end
        if (ovr_set)
        begin
            next_s.ctrl.overrun = 1'b1;
        end
        if (perr_set)
        begin
            next_s.ctrl.parity_err = 1'b1;
        end
        next_s.ctrl.rx_extra_bit = next_s.fifo[0].extra;
        next_s.irq = next_s.bctl.irq_enable
            & (next_s.ctrl.transmit_done_flag | next_s.ctrl.receive_ready_flag);
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s <= '{ctrl: CONTROL_STATUS_RESET, fmt: FORMAT_CONFIG_RESET, bctl: BAUD_GEN_CONTROL_RESET,
                   reload: BAUD_RELOAD_RESET, tx: PH_IDLE, rx: PH_IDLE, txd: 1'b1, sync: 3'h7,
                   rx_lvl: 1'b1, default: '0};
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule // serial_port

// ### bench/serial_port_chk.sv
// Port-level assertions for the serial port
module serial_port_chk
    import serial_port_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic rxd_i,
    input wire logic txd_o,
    input wire logic serial_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic acc;
    logic acc_w;
    assign acc = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
    assign acc_w = avs_write_i & ~avs_waitrequest_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_one_wait;
        avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence
    property p_req_wait;
        $rose(avs_read_i | avs_write_i) |-> s_one_wait;
    endproperty
    property p_wait_req;
        avs_waitrequest_o |-> avs_read_i | avs_write_i;
    endproperty
    property p_rdata_hold;
        // Loaded in the wait cycle, so the new value is first seen at the accepting edge
        $changed(avs_readdata_o) |-> acc;
    endproperty
    property p_wr_zero;
        acc_w |=> avs_readdata_o == 32'h0000_0000;
    endproperty
    property p_rdata_top;
        avs_readdata_o[31:8] == 24'h00_0000;
    endproperty
    property p_start_min;
        $fell(txd_o) |=> !txd_o;
    endproperty
    property p_irq_fall;
        $fell(serial_irq_o) |-> $past(acc_w) || $past(acc_w, 2);
    endproperty
    property p_wait_drop;
        avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_req_wait: assert property (p_req_wait) else $error("no single wait state");
    a_wait_req: assert property (p_wait_req) else $error("wait without request");
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    a_wr_zero: assert property (p_wr_zero) else $error("read data not cleared by write");
    a_rdata_top: assert property (p_rdata_top) else $error("read data upper bits set");
    a_start_min: assert property (p_start_min) else $error("start bit too short");
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped by itself");
    a_wait_drop: assert property (p_wait_drop) else $error("wait longer than one cycle");
endmodule // serial_port_chk

bind serial_port serial_port_chk u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .rxd_i(rxd_i), .txd_o(txd_o), .serial_irq_o(serial_irq_o));

// ### bench/serial_node.sv
// Remote serial node: drives the receive line and decodes the transmit line
module serial_node
#(
    parameter int BIT = 16
)
(
    input wire logic clk_i,
    input wire logic txd_i,
    output logic rxd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rxd_o = 1'b1;
    task automatic send(input int nb, input logic [8:0] d, input logic st);
        @(posedge clk_i);
        rxd_o <= 1'b0;
        repeat (BIT) @(posedge clk_i);
        for (int i = 0; i < nb; i++)
        begin
            rxd_o <= d[i];
            repeat (BIT) @(posedge clk_i);
        end
        rxd_o <= st;
        repeat (BIT) @(posedge clk_i);
        // Line idles high between frames, like a pulled-up wire
        rxd_o <= 1'b1;
        repeat (3 * BIT) @(posedge clk_i);
    endtask
    // Samples at negedge so the registered line has settled
    task automatic recv(input int nb, output logic [8:0] d, output logic st);
        int n = 0;
        d = '0;
        while (txd_i !== 1'b0 && n < 9000)
        begin
            @(negedge clk_i);
            n++;
        end
        repeat (BIT / 2) @(negedge clk_i);
        for (int i = 0; i < nb; i++)
        begin
            repeat (BIT) @(negedge clk_i);
            d[i] = txd_i;
        end
        repeat (BIT) @(negedge clk_i);
        st = txd_i;
    endtask
endmodule // serial_node

// ### bench/tb_serial_port.sv
// Self-checking testbench for the serial port
module tb_serial_port;
    import serial_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // Reload 0xFFF8 at divide by 1 gives 2 * 8 = 16 clocks a bit
    localparam int BIT = 16;
    localparam logic [4:0] A_CS = OFS_SERIAL_CONTROL_STATUS;
    localparam logic [4:0] A_FMT = OFS_SERIAL_FORMAT_CONFIG;
    localparam logic [4:0] A_DAT = OFS_SERIAL_DATA_PORT;
    localparam logic [4:0] A_BC = OFS_BAUD_GEN_CONTROL;
    localparam logic [3:0] PAR_EXP = 4'b0110;
    localparam logic [4:0] OFS [6] = '{A_CS, A_FMT, A_BC, OFS_BAUD_RELOAD_HIGH, OFS_BAUD_RELOAD_LOW, 5'h18};
    localparam logic [7:0] RST [6] = '{CONTROL_STATUS_RESET, FORMAT_CONFIG_RESET, BAUD_GEN_CONTROL_RESET, 8'h00,
        8'h00, 8'h00};
    logic clk_i = 1'b0, rst_b_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [4:0] avs_address_i = 5'h00;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o, rxd_i, txd_o, serial_irq_o;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    serial_port dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'h1),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .rxd_i(rxd_i), .txd_o(txd_o),
        .serial_irq_o(serial_irq_o));
    serial_node #(.BIT(BIT)) node (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));
    always #5 clk_i = ~clk_i;
    task print_verdict();
        $display("tests %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            print_verdict();
        end
    end
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Wait state and read data are taken at the rising edge, before that edge's own updates land
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= {24'h00_0000, d};
        avs_write_i <= w;
        avs_read_i <= ~w;
        do
        begin
            @(posedge clk_i);
        end
        while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        check(q, {24'h00_0000, e});
    endtask
    task automatic t_regs();
        wr(5'h18, 8'h55);
        for (int i = 0; i < 6; i++)
            rd_chk(OFS[i], RST[i]);
        wr(OFS_BAUD_RELOAD_HIGH, 8'hFF);
        wr(OFS_BAUD_RELOAD_LOW, 8'hF8);
        wr(A_BC, 8'hC3);
        wr(A_CS, 8'h10);
        rd_chk(OFS_BAUD_RELOAD_LOW, 8'hF8);
        rd_chk(A_BC, 8'hC3);
        rd_chk(A_CS, 8'h30);
        $display("test regs done");
    endtask
    task automatic t_tx();
        logic [8:0] q;
        logic st;
        for (int l = 0; l < 4; l++)
        begin
            wr(A_FMT, 8'(l << 2));
            fork
                node.recv(5 + l, q, st);
                wr(A_DAT, 8'hA5);
            join
            check(q, {1'b0, 8'hA5 & (8'hFF >> (3 - l))});
            check(st, 1'b1);
        end
        for (int t = 0; t < 4; t++)
        begin
            wr(A_FMT, 8'h4C | 8'(t << 4));
            fork
                node.recv(9, q, st);
                wr(A_DAT, 8'h07);
            join
            check(q, {PAR_EXP[t], 8'h07});
        end
        check(serial_irq_o, 1'b1);
        rd_chk(A_CS, 8'h32);
        wr(A_CS, 8'h10);
        rd_chk(A_CS, 8'h30);
        check(serial_irq_o, 1'b0);
        $display("test tx done");
    endtask
    task automatic t_rx();
        wr(A_FMT, 8'h0C);
        for (int i = 1; i < 5; i++)
            node.send(8, 9'(8'h11 * i), 1'b1);
        rd_chk(A_CS, 8'hB5);
        wr(A_CS, 8'h90);
        rd_chk(A_CS, 8'hB5);
        rd_chk(A_DAT, 8'h11);
        rd_chk(A_DAT, 8'h22);
        wr(A_CS, 8'h10);
        rd_chk(A_CS, 8'h34);
        rd_chk(A_DAT, 8'h33);
        node.send(8, 9'h05A, 1'b0);
        // An empty queue still shows the extra bit of the last head entry
        rd_chk(A_CS, 8'h34);
        wr(A_FMT, 8'h8E);
        node.send(9, 9'h042, 1'b1);
        rd_chk(A_CS, 8'h30);
        node.send(9, 9'h143, 1'b1);
        rd_chk(A_CS, 8'h31);
        rd_chk(A_DAT, 8'h42);
        wr(A_FMT, 8'h5C);
        node.send(9, 9'h007, 1'b1);
        rd_chk(A_CS, 8'h75);
        $display("test rx done");
    endtask
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_regs();
        t_tx();
        t_rx();
        print_verdict();
    end
endmodule // tb_serial_port
